// file: hw/sfp_pkg.sv
package sfp_pkg;
   // link opcodes
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_READ_STATUS  = 8'h05;
   localparam logic [7:0] OP_PROG_1L_3B   = 8'h02;
   localparam logic [7:0] OP_PROG_1L_4B   = 8'h12;
   localparam logic [7:0] OP_PROG_4L_3B   = 8'h32;
   localparam logic [7:0] OP_PROG_4L_4B   = 8'h34;
   localparam logic [7:0] OP_PROG_X4_3B   = 8'hc2;
   localparam logic [7:0] OP_PROG_X4_4B   = 8'h3e;
   // address framing
   localparam logic [2:0] ADDR_BYTES_3    = 3'h3;
   localparam logic [2:0] ADDR_BYTES_4    = 3'h4;
   localparam int         PAGE_BYTES      = 256;
   // status byte layout on the link
   localparam int         STAT_BUSY_BIT   = 0;
   localparam int         STAT_LATCH_BIT  = 1;
   // protection: 64 KB blocks of a 128 MB array, counted from the top
   localparam int         BLK_LSB         = 16;
   localparam int         BLK_MSB         = 26;
   localparam logic [11:0] BLK_TOTAL      = 12'h800;
   localparam logic [4:0] PROT_ALL_CODE   = 5'h0c;
   // program cycle time; a longest time, so it rounds down
   localparam int         TPP_US          = 400;
   localparam int         MCLK_KHZ        = 10000;
   localparam int         TPP_CYC         = (TPP_US * MCLK_KHZ) / 1000;
   // host serial clock half period in mclk cycles
   localparam logic [2:0] SCLK_HALF       = 3'h4;
   // host register map (byte addresses)
   localparam logic [7:0] REG_CTRL        = 8'h00;
   localparam logic [7:0] REG_COUNT       = 8'h04;
   localparam logic [7:0] REG_ADDR        = 8'h08;
   localparam logic [7:0] REG_DATA        = 8'h0c;
   localparam logic [7:0] REG_STATUS      = 8'h10;
   localparam logic [7:0] REG_IRQ_STAT    = 8'h14;
   localparam logic [7:0] REG_IRQ_CLR     = 8'h18;
   localparam logic [7:0] REG_IRQ_EN      = 8'h1c;
   // ctrl fields: [7:0] opcode, [10:8] address bytes, [11] quad, [12] read
   localparam int         CTRL_ALEN_LSB   = 8;
   localparam int         CTRL_QUAD_BIT   = 11;
   localparam int         CTRL_READ_BIT   = 12;
   localparam int         CTRL_W          = 13;
   localparam int         COUNT_W         = 9;
   localparam int         STAT_RX_LSB     = 8;
   localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
   localparam logic [COUNT_W-1:0] COUNT_RST = 9'h000;
endpackage

// file: hw/sfp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfp_link_if;
   logic       sclk;
   logic       cs_n;
   logic [3:0] h_io_o;
   logic [3:0] h_io_oe;
   logic [3:0] d_io_o;
   logic [3:0] d_io_oe;
   logic [3:0] io;
   // undriven lines read high, as with board pull-ups; the device wins a clash
   assign io = (d_io_oe & d_io_o) | (~d_io_oe & h_io_oe & h_io_o) | (~d_io_oe & ~h_io_oe);
   modport dev (input sclk, input cs_n, input io, output d_io_o, output d_io_oe);
   modport host (output sclk, output cs_n, input io, output h_io_o, output h_io_oe);
endinterface
`default_nettype wire

// file: hw/sfp_dev.sv
// Summary of operation
// RULE1: program runs only with write latch set
// RULE2: opcodes 02h/12h program over one line
// RULE3: opcodes 32h/34h program over four lines
// RULE4: opcodes c2h/3eh also program over four lines
// RULE5: four-line variants use all data lines
// RULE6: host frames opcode, address, data, deselect
// RULE7: host keeps select low whole transaction
// RULE8: data past page end wraps to offset zero
// RULE9: over 256 bytes, last 256 kept
// RULE10: short payload leaves other page bytes untouched
// RULE11: select rise off byte boundary aborts command
// RULE12: valid select rise starts timed program cycle
// RULE13: busy flag high exactly during program cycle
// RULE14: write latch cleared before cycle ends
// RULE15: protected pages refuse program, memory unchanged
// RULE16: 24-bit address, 32-bit in four-byte mode; the code also takes 32 bits for opcodes 12h/34h/3eh in any mode
// RULE17: device samples link bits on rising clock
// RULE18: program commands ignored while cycle runs
`timescale 1ns/1ps
`default_nettype none
module sfp_dev (
   input  wire logic        mclk,
   input  wire logic        nrst,
   sfp_link_if.dev          link,
   input  wire logic        four_byte_mode,
   input  wire logic [4:0]  protect_field,
   output logic             busy_flag,
   output logic             write_latch_bit,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [7:0]       mem_data
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_DATA = 3'h2,
      ST_STAT = 3'h3,
      ST_WRITE_ENABLE_CMD = 3'h4,
      ST_SKIP = 3'h5
   } sfp_dev_state_e;

   sfp_dev_state_e state_q;
   logic [1:0]  sclk_s;
   logic [1:0]  cs_s;
   logic [3:0]  io_s0;
   logic [3:0]  io_s1;
   logic        sclk_p_q;
   logic        cs_p_q;
   logic [7:0]  sh_q;
   logic [2:0]  bcnt_q;
   logic        quad_q;
   logic [2:0]  alen_q;
   logic [31:0] addr_q;
   logic [7:0]  idx_q;
   logic        got_q;
   logic [255:0] mask_q;
   logic [7:0]  buf_mem [0:255];
   logic [11:0] tcnt_q;
   logic [23:0] page_q;
   logic [2:0]  scnt_q;
   logic        dout_q;
   logic        busy_q;
   logic        latch_q;
   logic        we_q;
   logic [31:0] maddr_q;
   logic [7:0]  mdata_q;

   // link pins are asynchronous to mclk: two flops before anything reads them
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sclk_s   <= 2'h0;
         cs_s     <= 2'h3;
         io_s0    <= 4'hf;
         io_s1    <= 4'hf;
         sclk_p_q <= 1'b0;
         cs_p_q   <= 1'b1;
      end else begin
         sclk_s   <= {sclk_s[0], link.sclk};
         cs_s     <= {cs_s[0], link.cs_n};
         io_s0    <= link.io;
         io_s1    <= io_s0;
         sclk_p_q <= sclk_s[1];
         cs_p_q   <= cs_s[1];
      end
   end

   // edge finding and byte assembly
   wire        sclk_rise = sclk_s[1] & ~sclk_p_q & ~cs_s[1]; // RULE17
   wire        sclk_fall = ~sclk_s[1] & sclk_p_q & ~cs_s[1];
   wire        cs_rise   = cs_s[1] & ~cs_p_q;
   wire        quad_now  = quad_q & ((state_q == ST_ADDR) | (state_q == ST_DATA)); // RULE5
   wire [3:0]  bsum      = {1'b0, bcnt_q} + (quad_now ? 4'h4 : 4'h1);
   wire        byte_done = bsum[3];
   wire [7:0]  sh_d      = quad_now ? {sh_q[3:0], io_s1} : {sh_q[6:0], io_s1[0]};

   // opcode decode on the completed first byte
   wire op_1l = (sh_d == sfp_pkg::OP_PROG_1L_3B) | (sh_d == sfp_pkg::OP_PROG_1L_4B); // RULE2
   wire op_4l = (sh_d == sfp_pkg::OP_PROG_4L_3B) | (sh_d == sfp_pkg::OP_PROG_4L_4B) // RULE3
              | (sh_d == sfp_pkg::OP_PROG_X4_3B) | (sh_d == sfp_pkg::OP_PROG_X4_4B); // RULE4
   wire op_4b = (sh_d == sfp_pkg::OP_PROG_1L_4B) | (sh_d == sfp_pkg::OP_PROG_4L_4B)
              | (sh_d == sfp_pkg::OP_PROG_X4_4B);
   // four-byte opcodes always take 32 bits; the others follow the mode pin
   wire [2:0] alen_d = (op_4b | four_byte_mode) ? sfp_pkg::ADDR_BYTES_4
                                                 : sfp_pkg::ADDR_BYTES_3; // RULE16

   // protection covers the top 2^(code-1) blocks; large codes cover the array
   wire [11:0] prot_blocks = (protect_field >= sfp_pkg::PROT_ALL_CODE) ? sfp_pkg::BLK_TOTAL
                           : (12'h001 << (protect_field - 5'h01));
   wire [11:0] addr_blk    = {1'b0, addr_q[sfp_pkg::BLK_MSB:sfp_pkg::BLK_LSB]};
   wire        prot_hit    = (protect_field != 5'h00)
                           & (addr_blk >= (sfp_pkg::BLK_TOTAL - prot_blocks)); // RULE15

   // execution needs a whole-byte end, data, the latch, no protection, idle engine
   wire start = cs_rise & (state_q == ST_DATA) & (bcnt_q == 3'h0) & got_q // RULE11
              & latch_q & ~prot_hit & ~busy_q; // RULE1 RULE15 RULE18
   wire write_enable_cmd_set = cs_rise & (state_q == ST_WRITE_ENABLE_CMD) & (bcnt_q == 3'h0) & ~busy_q;
   wire buf_wr = sclk_rise & byte_done & (state_q == ST_DATA);

   // command state machine; a high select always returns to idle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         sh_q    <= 8'h00;
         bcnt_q  <= 3'h0;
         quad_q  <= 1'b0;
         alen_q  <= 3'h0;
         addr_q  <= 32'h0000_0000;
         idx_q   <= 8'h00;
         got_q   <= 1'b0;
      end else if (cs_s[1]) begin
         state_q <= ST_IDLE; // RULE7
         bcnt_q  <= 3'h0;
         quad_q  <= 1'b0;
      end else if (sclk_rise) begin
         sh_q   <= sh_d;
         bcnt_q <= bsum[2:0];
         if (byte_done) begin
            unique case (state_q)
               ST_IDLE: begin
                  got_q  <= 1'b0;
                  addr_q <= 32'h0000_0000;
                  alen_q <= alen_d;
                  quad_q <= op_4l;
                  if (sh_d == sfp_pkg::OP_READ_STATUS) begin
                     state_q <= ST_STAT; // RULE13
                  end else if (sh_d == sfp_pkg::OP_WRITE_ENABLE) begin
                     state_q <= ST_WRITE_ENABLE_CMD;
                  end else if ((op_1l | op_4l) & ~busy_q) begin
                     state_q <= ST_ADDR; // RULE6 RULE18
                  end else begin
                     state_q <= ST_SKIP;
                  end
               end
               ST_ADDR: begin
                  addr_q <= {addr_q[23:0], sh_d};
                  alen_q <= alen_q - 3'h1;
                  if (alen_q == 3'h1) begin
                     state_q <= ST_DATA;
                     idx_q   <= sh_d; // start offset in page
                  end
               end
               ST_DATA: begin
                  idx_q <= idx_q + 8'h01; // RULE8
                  got_q <= 1'b1;
               end
               ST_STAT: state_q <= ST_STAT;
               ST_WRITE_ENABLE_CMD: state_q <= ST_SKIP;
               ST_SKIP: state_q <= ST_SKIP;
               default: state_q <= ST_SKIP;
            endcase
         end
      end
   end

   // page buffer: a later byte at the same offset replaces the earlier one
   always_ff @(posedge mclk) begin
      if (buf_wr) begin
         buf_mem[idx_q] <= sh_d; // RULE9
      end
   end

   // byte-valid mask, cleared when a program command is accepted
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mask_q <= '0;
      end else if (sclk_rise & byte_done & (state_q == ST_IDLE) & (op_1l | op_4l) & ~busy_q) begin
         mask_q <= '0;
      end else if (buf_wr) begin
         mask_q[idx_q] <= 1'b1; // RULE10
      end
   end

   // self-timed program cycle; the latch drops as it begins
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         busy_q  <= 1'b0;
         latch_q <= 1'b0;
         tcnt_q  <= 12'h000;
         page_q  <= 24'h00_0000;
      end else if (start) begin
         busy_q  <= 1'b1; // RULE12 RULE13
         latch_q <= 1'b0; // RULE14
         tcnt_q  <= 12'h000;
         page_q  <= addr_q[31:8];
      end else begin
         if (write_enable_cmd_set) begin
            latch_q <= 1'b1; // RULE1
         end
         if (busy_q) begin
            tcnt_q <= tcnt_q + 12'h001;
            if (tcnt_q == 12'(sfp_pkg::TPP_CYC - 1)) begin
               busy_q <= 1'b0; // RULE13
            end
         end
      end
   end

   // the first page-size cycles of the program walk the buffer; unmarked bytes stay
   wire walk = busy_q & (tcnt_q < 12'(sfp_pkg::PAGE_BYTES));
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         we_q    <= 1'b0;
         maddr_q <= 32'h0000_0000;
         mdata_q <= 8'h00;
      end else begin
         we_q    <= walk & mask_q[tcnt_q[7:0]]; // RULE10
         maddr_q <= {page_q, tcnt_q[7:0]}; // RULE8
         mdata_q <= buf_mem[tcnt_q[7:0]];
      end
   end

   // status byte goes out msb first on data_line1, changed on falling clock
   wire [7:0] stat_byte = {6'h00, latch_q, busy_q};
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         scnt_q <= 3'h0;
         dout_q <= 1'b0;
      end else if (state_q != ST_STAT) begin
         scnt_q <= 3'h0;
      end else if (sclk_fall) begin
         dout_q <= stat_byte[~scnt_q]; // RULE13
         scnt_q <= scnt_q + 3'h1;
      end
   end

   assign link.d_io_o    = {2'h0, dout_q, 1'b0};
   assign link.d_io_oe   = {2'h0, (state_q == ST_STAT), 1'b0};
   assign busy_flag       = busy_q;
   assign write_latch_bit = latch_q;
   assign mem_we          = we_q;
   assign mem_addr        = maddr_q;
   assign mem_data        = mdata_q;
endmodule
`default_nettype wire

// file: hw/sfp_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
   input  wire logic        mclk,
   input  wire logic        nrst,
   sfp_link_if.host         link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq
);
   typedef enum logic [1:0] {
      SEG_OP   = 2'h0,
      SEG_ADDR = 2'h1,
      SEG_DATA = 2'h2
   } sfp_seg_e;

   logic [sfp_pkg::CTRL_W-1:0]  ctrl_q;
   logic [sfp_pkg::COUNT_W-1:0] count_q;
   logic [31:0] addr_q;
   logic [31:0] data_q;
   logic [31:0] prdata_q;
   logic        irq_st_q;
   logic        irq_en_q;
   logic        run_q;
   sfp_seg_e    seg_q;
   logic [sfp_pkg::COUNT_W-1:0] left_q;
   logic [2:0]  bitpos_q;
   logic [2:0]  div_q;
   logic [1:0]  didx_q;
   logic        sclk_q;
   logic        csn_q;
   logic [3:0]  io_o_q;
   logic [3:0]  io_oe_q;
   logic [7:0]  rx_q;
   logic [3:0]  io_s0;
   logic [3:0]  io_s1;

   // apb decode; zero wait states, unmapped reads give zero with an error
   wire        wr_acc   = psel & penable & pwrite;
   wire        setup    = psel & ~penable;
   wire        mapped   = (paddr <= sfp_pkg::REG_IRQ_EN) & (paddr[1:0] == 2'h0);
   wire        go       = wr_acc & (paddr == sfp_pkg::REG_CTRL) & ~run_q;
   wire        irq_clr  = wr_acc & (paddr == sfp_pkg::REG_IRQ_CLR) & pwdata[0];
   wire [31:0] stat_w   = {16'h0000, rx_q, 7'h00, run_q};
   wire [31:0] rd_mux   = (paddr == sfp_pkg::REG_CTRL)     ? {19'h0, ctrl_q}
                        : (paddr == sfp_pkg::REG_COUNT)    ? {23'h0, count_q}
                        : (paddr == sfp_pkg::REG_ADDR)     ? addr_q
                        : (paddr == sfp_pkg::REG_DATA)     ? data_q
                        : (paddr == sfp_pkg::REG_STATUS)   ? stat_w
                        : (paddr == sfp_pkg::REG_IRQ_STAT) ? {31'h0, irq_st_q}
                        : (paddr == sfp_pkg::REG_IRQ_EN)   ? {31'h0, irq_en_q}
                        : 32'h0000_0000;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_q;
   assign irq     = irq_st_q & irq_en_q;

   // register writes; ctrl is locked while a transfer runs
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q   <= sfp_pkg::CTRL_RST;
         count_q  <= sfp_pkg::COUNT_RST;
         addr_q   <= 32'h0000_0000;
         data_q   <= 32'h0000_0000;
         irq_en_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         if (setup) prdata_q <= rd_mux;
         if (go) ctrl_q <= pwdata[sfp_pkg::CTRL_W-1:0];
         if (wr_acc & (paddr == sfp_pkg::REG_COUNT)) count_q <= pwdata[sfp_pkg::COUNT_W-1:0];
         if (wr_acc & (paddr == sfp_pkg::REG_ADDR)) addr_q <= pwdata;
         if (wr_acc & (paddr == sfp_pkg::REG_DATA)) data_q <= pwdata;
         if (wr_acc & (paddr == sfp_pkg::REG_IRQ_EN)) irq_en_q <= pwdata[0];
      end
   end

   // link sequencing: decode of the current slot from the go-time settings
   wire [2:0] alen    = go ? pwdata[sfp_pkg::CTRL_ALEN_LSB +: 3]
                           : ctrl_q[sfp_pkg::CTRL_ALEN_LSB +: 3];
   wire       quad    = ctrl_q[sfp_pkg::CTRL_QUAD_BIT] & (seg_q != SEG_OP); // RULE5
   wire       rd_seg  = ctrl_q[sfp_pkg::CTRL_READ_BIT] & (seg_q == SEG_DATA);
   wire [7:0] cur     = (seg_q == SEG_OP)   ? ctrl_q[7:0]
                      : (seg_q == SEG_ADDR) ? addr_q[{left_q[1:0] - 2'h1, 3'h0} +: 8]
                      : data_q[{didx_q, 3'h0} +: 8];
   wire [2:0] tick_end = {sfp_pkg::SCLK_HALF[1:0], 1'b0} - 3'h1;
   wire       slot_end = run_q & (div_q == tick_end);
   wire       byte_end = slot_end & (bitpos_q == (quad ? 3'h3 : 3'h0));
   wire       seg_end  = byte_end & (left_q == 9'h001);
   wire       to_data  = (count_q != 9'h000);
   wire       fin      = seg_end & ((seg_q == SEG_DATA) | ((seg_q == SEG_ADDR) & ~to_data)
                       | ((seg_q == SEG_OP) & (alen == 3'h0) & ~to_data)); // RULE6

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         run_q <= 1'b0;
         seg_q <= SEG_OP;
         left_q <= 9'h000;
         bitpos_q <= 3'h7;
         div_q <= 3'h0;
         didx_q <= 2'h0;
         sclk_q <= 1'b0;
         csn_q <= 1'b1;
      end else if (go) begin
         run_q <= 1'b1;
         csn_q <= 1'b0; // RULE7
         seg_q <= SEG_OP;
         left_q <= 9'h001;
         bitpos_q <= 3'h7;
         div_q <= 3'h0;
         didx_q <= 2'h0;
      end else if (run_q) begin
         div_q <= (div_q == tick_end) ? 3'h0 : div_q + 3'h1;
         if (div_q == 3'h0) sclk_q <= 1'b0;
         if (div_q == sfp_pkg::SCLK_HALF) sclk_q <= 1'b1; // RULE17
         if (slot_end) bitpos_q <= bitpos_q - (quad ? 3'h4 : 3'h1);
         if (byte_end) begin
            bitpos_q <= 3'h7;
            left_q <= left_q - 9'h001;
            if (seg_q == SEG_DATA) didx_q <= didx_q + 2'h1;
         end
         if (seg_end & (seg_q == SEG_OP) & (alen != 3'h0)) begin
            seg_q <= SEG_ADDR; // RULE16
            left_q <= {6'h00, alen};
         end else if (seg_end & (seg_q != SEG_DATA) & to_data) begin
            seg_q <= SEG_DATA;
            left_q <= count_q;
         end
         if (fin) begin
            run_q <= 1'b0;
            csn_q <= 1'b1; // RULE11
            sclk_q <= 1'b0;
         end
      end
   end

   // drive at the low half; quad slots carry a nibble on all four lines
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         io_o_q <= 4'h0;
         io_oe_q <= 4'h0;
      end else if (~run_q | fin) begin
         io_oe_q <= 4'h0;
      end else if (div_q == 3'h0 || go) begin
         io_o_q <= quad ? (bitpos_q[2] ? cur[7:4] : cur[3:0]) : {3'h0, cur[bitpos_q]};
         io_oe_q <= rd_seg ? 4'h0 : (quad ? 4'hf : 4'h1); // RULE5
      end
   end

   // read data is synchronised and taken at the end of each high half
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         io_s0 <= 4'hf;
         io_s1 <= 4'hf;
         rx_q <= 8'h00;
         irq_st_q <= 1'b0;
      end else begin
         io_s0 <= link.io;
         io_s1 <= io_s0;
         if (slot_end & rd_seg) rx_q <= {rx_q[6:0], io_s1[1]};
         irq_st_q <= (irq_st_q & ~irq_clr) | fin; // set wins over clear
      end
   end

   assign link.sclk    = sclk_q;
   assign link.cs_n    = csn_q;
   assign link.h_io_o  = io_o_q;
   assign link.h_io_oe = io_oe_q;
endmodule
`default_nettype wire

// file: test/sfp_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches the device side of the link between the two ends
module sfp_chk (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        cs_n,
   input wire logic [4:0]  protect_field,
   input wire logic        busy_flag,
   input wire logic        write_latch_bit,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr
);
   localparam int TPP = sfp_pkg::TPP_CYC;
   logic [15:0] cnt_q;
   logic        seen_q;
   logic [31:0] last_q;
   // busy length and write order, both forgotten while idle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q  <= 16'h0000;
         seen_q <= 1'b0;
         last_q <= 32'h0;
      end else if (!busy_flag) begin
         cnt_q  <= 16'h0000;
         seen_q <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         if (mem_we) begin
            seen_q <= 1'b1;
            last_q <= mem_addr;
         end
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_latch_before_go: assert property ($rose(busy_flag) |-> $past(write_latch_bit))
      else $error("program began without write latch");
   a_go_deselected: assert property ($rose(busy_flag) |-> cs_n)
      else $error("program began while selected");
   a_latch_cleared: assert property ($rose(busy_flag) |-> !write_latch_bit)
      else $error("write latch kept at program start");
   a_busy_length: assert property ($fell(busy_flag) |-> cnt_q >= 16'(TPP-8) && cnt_q <= 16'(TPP+1))
      else $error("program cycle length wrong");
   a_we_in_cycle: assert property (mem_we |-> busy_flag && !write_latch_bit)
      else $error("memory write outside program cycle");
   a_we_one_page: assert property (mem_we && seen_q |->
      mem_addr[7:0] > last_q[7:0] && mem_addr[31:8] == last_q[31:8])
      else $error("memory write left page or order");
   a_we_unprotected: assert property (mem_we |-> protect_field != sfp_pkg::PROT_ALL_CODE)
      else $error("protected page written");
   a_busy_no_latch: assert property (busy_flag |-> !$rose(write_latch_bit))
      else $error("write enable taken while busy");
   // main scenarios reached
   c_cycle_end: cover property ($fell(busy_flag));
   c_burst: cover property (mem_we && seen_q);
   c_latch: cover property ($rose(write_latch_bit));
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] DATW = 32'h44332211;
   localparam logic [31:0] DATW2 = 32'hddccbbaa;
   logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, irq, sl_v;
   logic        four_byte_mode, busy_flag, write_latch_bit, mem_we;
   logic [4:0]  protect_field;
   logic [7:0]  paddr, mem_data, img[256];
   logic [31:0] pwdata, prdata, mem_addr, rd_v;
   logic        hit[256];
   logic [39:0] got_q[$];
   logic [12:0] ops[7] = '{13'h0302, 13'h0412, 13'h0b32, 13'h0c34, 13'h0bc2, 13'h0c3e, 13'h1402};
   int          err_total = 0;
   int          compares = 0;
   int          cyc = 0;
   sfp_link_if link ();
   sfp_dev sfp_dev_i (.mclk(mclk), .nrst(nrst), .link(link), .four_byte_mode(four_byte_mode),
      .protect_field(protect_field), .busy_flag(busy_flag), .write_latch_bit(write_latch_bit),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_data(mem_data));
   sfp_host sfp_host_i (.mclk(mclk), .nrst(nrst), .link(link), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq));
   sfp_chk sfp_chk_i (.mclk(mclk), .nrst(nrst), .cs_n(link.cs_n),
      .protect_field(protect_field), .busy_flag(busy_flag), .write_latch_bit(write_latch_bit),
      .mem_we(mem_we), .mem_addr(mem_addr));
   // clock, memory write log and hang guard
   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      if (mem_we === 1'b1) got_q.push_back({mem_addr, mem_data});
      cyc++;
      if (cyc == 100000) begin
         err_total++;
         test_done();
      end
   end
   task automatic test_done;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; waits an edge first so no signal is assigned twice in a step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd_v = prdata;
      sl_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one link transfer, finished when the done interrupt shows
   task automatic xfer(input logic [12:0] c, input logic [31:0] a, input logic [8:0] n);
      apb(1'b1, sfp_pkg::REG_ADDR, a);
      apb(1'b1, sfp_pkg::REG_COUNT, {23'h0, n});
      apb(1'b1, sfp_pkg::REG_DATA, DATW);
      apb(1'b1, sfp_pkg::REG_CTRL, {19'h0, c});
      while (irq !== 1'b1) @(posedge mclk);
      apb(1'b1, sfp_pkg::REG_IRQ_CLR, 32'h1);
   endtask
   task automatic prog(input logic [12:0] c, input logic [31:0] a, input logic [8:0] n);
      xfer({5'h00, sfp_pkg::OP_WRITE_ENABLE}, 32'h0, 9'h000);
      xfer(c, a, n);
   endtask
   task automatic stat(input logic [7:0] e);
      xfer({5'h10, sfp_pkg::OP_READ_STATUS}, 32'h0, 9'h001);
      apb(1'b0, sfp_pkg::REG_STATUS, 32'h0);
      chk({32'h0, rd_v[15:8]}, {32'h0, e});
   endtask
   // sync delay lets busy rise before waiting for its end
   task automatic settle;
      repeat (4) @(posedge mclk);
      while (busy_flag !== 1'b0) @(posedge mclk);
   endtask
   // last byte per offset wins; writes come in ascending offset order;
   // bytes from index s on carry the second data word
   task automatic expect_w(input logic [31:0] a, input int n, input int s = 512);
      logic [39:0] g;
      foreach (hit[i]) hit[i] = 1'b0;
      for (int i = 0; i < n; i++) begin
         hit[(a[7:0] + i) % 256] = 1'b1;
         img[(a[7:0] + i) % 256] = (i < s) ? DATW[8*(i%4)+:8] : DATW2[8*(i%4)+:8];
      end
      for (int j = 0; j < 256; j++) begin
         if (hit[j]) begin
            g = (got_q.size() > 0) ? got_q.pop_front() : 40'h0;
            chk(g, {a[31:8], 8'(j), img[j]});
         end
      end
      chk(40'(got_q.size()), 40'h0);
      got_q.delete();
   endtask
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      four_byte_mode = 1'b0;
      protect_field = 5'h00;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({39'h0, irq}, 40'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({7'h0, sl_v, rd_v}, {8'h01, 32'h0});
      // write enable with interrupt masked, then unmask and clear
      apb(1'b1, sfp_pkg::REG_CTRL, {24'h0, sfp_pkg::OP_WRITE_ENABLE});
      do apb(1'b0, sfp_pkg::REG_STATUS, 32'h0); while (rd_v[0] !== 1'b0);
      chk({39'h0, irq}, 40'h0);
      apb(1'b1, sfp_pkg::REG_IRQ_EN, 32'h1);
      @(posedge mclk);
      chk({39'h0, irq}, 40'h1);
      apb(1'b1, sfp_pkg::REG_IRQ_CLR, 32'h1);
      @(posedge mclk);
      chk({39'h0, irq}, 40'h0);
      stat(8'h02);
      // wrap in page, status while busy, commands ignored while busy
      prog(13'h0302, 32'h000001fe, 9'h004);
      stat(8'h01);
      prog(13'h0302, 32'h00000300, 9'h001);
      settle();
      expect_w(32'h000001fe, 4);
      stat(8'h00);
      // program without the latch
      xfer(13'h0302, 32'h00000400, 9'h001);
      settle();
      expect_w(32'h00000400, 0);
      // every program opcode and address width
      foreach (ops[k]) begin
         four_byte_mode <= ops[k][12];
         prog({1'b0, ops[k][11:0]}, (ops[k][10:8] == 3'h4) ? 32'h071234ff : 32'h001234ff, 9'h002);
         settle();
         expect_w((ops[k][10:8] == 3'h4) ? 32'h071234ff : 32'h001234ff, 2);
      end
      four_byte_mode <= 1'b0;
      // more than a page of quad data; the data word changes after byte 0 so the
      // wrapped tail differs from the head (8 enable + 14 command + 2 data rises)
      fork
         prog(13'h0b32, 32'h00005010, 9'h102);
         begin
            repeat (24) @(posedge link.sclk);
            apb(1'b1, sfp_pkg::REG_DATA, DATW2);
         end
      join
      settle();
      expect_w(32'h00005010, 258, 1);
      // address but no data byte: nothing is programmed
      prog(13'h0302, 32'h00000700, 9'h000);
      settle();
      expect_w(32'h00000700, 0);
      // whole array protected: refused, latch kept
      protect_field <= sfp_pkg::PROT_ALL_CODE;
      prog(13'h0302, 32'h00000600, 9'h001);
      settle();
      expect_w(32'h00000600, 0);
      stat(8'h02);
      test_done();
   end
endmodule
`default_nettype wire
